/* File: rtl/pcfs_pkg.sv */
package pcfs_pkg;

  // Register byte offsets
  localparam logic [31:0] PCFS_CTRL_OFS   = 32'h0000_0000;
  localparam logic [31:0] PCFS_STATUS_OFS = 32'h0000_0004;
  localparam logic [31:0] PCFS_PERIOD_OFS = 32'h0000_0008;

  // Control fields and reset value
  localparam int unsigned PCFS_CTRL_DOUBLE_BIT = 0;
  localparam int unsigned PCFS_CTRL_OE_BIT     = 1;
  localparam int unsigned PCFS_CTRL_CLR_BIT    = 2;
  localparam logic [2:0]  PCFS_CTRL_RESET      = 3'h2;

  // Status fields
  localparam int unsigned PCFS_ST_LOCK_BIT    = 0;
  localparam int unsigned PCFS_ST_PRESENT_BIT = 1;
  localparam int unsigned PCFS_ST_RANGE_BIT   = 2;
  localparam int unsigned PCFS_ST_SEL_LSB     = 4;
  localparam int unsigned PCFS_ST_OEN_BIT     = 6;
  localparam int unsigned PCFS_ST_TEST_BIT    = 7;

  // Oscillator divider taps: 2x, 1x and 1/2x of the reference
  localparam int unsigned PCFS_OSC_DBL  = 0;
  localparam int unsigned PCFS_OSC_UNI  = 1;
  localparam int unsigned PCFS_OSC_HALF = 2;

  // Timing: reference ranges in MHz, converted to hclk periods
  localparam int unsigned PCFS_HCLK_MHZ      = 100;
  localparam int unsigned PCFS_REF_B_MIN_MHZ = 25;
  localparam int unsigned PCFS_REF_B_MAX_MHZ = 50;
  localparam int unsigned PCFS_REF_A_MIN_MHZ = 50;
  localparam int unsigned PCFS_REF_A_MAX_MHZ = 100;
  localparam logic [15:0] PCFS_PER_B_MIN =
    16'(PCFS_HCLK_MHZ / PCFS_REF_B_MAX_MHZ);
  localparam logic [15:0] PCFS_PER_B_MAX =
    16'(PCFS_HCLK_MHZ / PCFS_REF_B_MIN_MHZ);
  localparam logic [15:0] PCFS_PER_A_MIN =
    16'(PCFS_HCLK_MHZ / PCFS_REF_A_MAX_MHZ);
  localparam logic [15:0] PCFS_PER_A_MAX =
    16'(PCFS_HCLK_MHZ / PCFS_REF_A_MIN_MHZ);

  typedef enum logic [1:0] {
    PCFS_SEL_ALL_UNI = 2'h0,
    PCFS_SEL_RSVD    = 2'h1,
    PCFS_SEL_B1_UNI  = 2'h2,
    PCFS_SEL_B12_UNI = 2'h3
  } pcfs_sel_e;

  typedef enum logic [1:0] {
    PCFS_LK_IDLE = 2'h0,
    PCFS_LK_ACQ  = 2'h1,
    PCFS_LK_LOCK = 2'h3
  } pcfs_lock_e;

  // Bank (0..2) takes the alternate rate (2x or 1/2x) for a select code
  function automatic logic pcfs_bank_alt(input logic [1:0] sel,
                                         input int unsigned bank);
    case (sel)
      PCFS_SEL_B1_UNI:  pcfs_bank_alt = (bank != 0);
      PCFS_SEL_B12_UNI: pcfs_bank_alt = (bank == 2);
      default:          pcfs_bank_alt = 1'b0;
    endcase
  endfunction

endpackage

/* File: rtl/pcfs_top.sv */
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// Operation
// R1: Twelve clock outputs in four banks of three from one differential reference.
// R2: Output phase counters restart on each reference rise, aligning frequency and phase.
// R3: Measured reference period is checked against the supported rate range.
// R4: System wires exactly one output back to the feedback input.
// R5: Fed-back output runs at the reference frequency.
// R6: Two select inputs set up to nine outputs to half or double rate.
// R7: Double-rate mode when a unity output is fed back; reference 25 to 50 MHz.
// R8: In double mode, unity outputs toggle at the reference frequency.
// R9: In double mode, doubled outputs toggle at twice the reference frequency.
// R10: Both selects low: banks one to three all run at unity rate.
// R11: One select code keeps bank one unity, doubles banks two to four.
// R12: Another select code keeps banks one and two unity, doubles three and four.
// R13: Output enable low enables outputs; high forces all outputs low. The code enables outputs only when the pin is low and control OE bit 1 is set.
// R14: Falling edge of clear input resets the quarter oscillator divider.
// R15: Test input high bypasses the loop, outputs follow the reference.
// R16: Bank four always runs at half the oscillator, ignoring selects; the code uses the 1x tap (a quarter of the oscillator) outside double mode.
// R17: Generated outputs have even duty cycle regardless of reference duty.
module pcfs_top
  import pcfs_pkg::*;
#(
  parameter int unsigned PER_W      = 16,
  parameter int unsigned LOCK_TOL   = 2,
  parameter int unsigned LOCK_COUNT = 4
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ref_clock_pair_p,
  input  wire logic        ref_clock_pair_n,
  input  wire logic        loop_feedback_in,
  input  wire logic        bank_cfg_select_hi,
  input  wire logic        bank_cfg_select_lo,
  input  wire logic        output_enable_n,
  input  wire logic        divider_clear_n,
  input  wire logic        test_bypass,
  output logic      [2:0]  bank1_clock_outputs,
  output logic      [2:0]  bank2_clock_outputs,
  output logic      [2:0]  bank3_clock_outputs,
  output logic      [2:0]  bank4_clock_outputs
);

  initial begin
    if (PER_W < 8 || PER_W > 31 || LOCK_COUNT < 1 || LOCK_COUNT > 15)
      $error("pcfs_top: unsupported parameter values");
  end

  // Pin synchronisers: p, n, fb, sel_hi, sel_lo, oe_n, clr_n, test
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  logic       ref_prev_q;
  logic       fb_prev_q;
  logic       clr_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q   <= 8'h00;
      pin_s2_q   <= 8'h00;
      ref_prev_q <= 1'b0;
      fb_prev_q  <= 1'b0;
      clr_prev_q <= 1'b1;
    end else if (ce) begin
      pin_s1_q   <= {test_bypass, divider_clear_n, output_enable_n,
                     bank_cfg_select_lo, bank_cfg_select_hi,
                     loop_feedback_in, ref_clock_pair_n, ref_clock_pair_p};
      pin_s2_q   <= pin_s1_q;
      ref_prev_q <= pin_s2_q[0] & ~pin_s2_q[1];
      fb_prev_q  <= pin_s2_q[2];
      clr_prev_q <= pin_s2_q[6];
    end
  end

  logic       ref_lvl;
  logic       ref_rise;
  logic       fb_rise;
  logic       clr_fall;
  logic [1:0] sel;
  logic       oen_s;
  logic       test_s;

  // Differential pair reads high only when the legs disagree that way
  assign ref_lvl  = pin_s2_q[0] & ~pin_s2_q[1];
  assign ref_rise = ref_lvl & ~ref_prev_q;
  assign fb_rise  = pin_s2_q[2] & ~fb_prev_q;
  assign clr_fall = ~pin_s2_q[6] & clr_prev_q;
  assign sel      = {pin_s2_q[3], pin_s2_q[4]};
  assign oen_s    = pin_s2_q[5];
  assign test_s   = pin_s2_q[7];

  // Register file over AHB-Lite, zero wait states
  logic [2:0]  ctrl_q;
  logic        sw_clr_q;
  logic        wr_pend_q;
  logic [31:0] wr_addr_q;
  logic        addr_ok;
  logic [31:0] rd_word;
  logic        locked;
  logic        present_q;
  logic        range_ok;
  logic [PER_W-1:0] period_q;

  assign addr_ok = hsel & hready & htrans[1];

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr)
      PCFS_CTRL_OFS:   rd_word[2:0] = ctrl_q;
      PCFS_STATUS_OFS: begin
        rd_word[PCFS_ST_LOCK_BIT]    = locked;
        rd_word[PCFS_ST_PRESENT_BIT] = present_q;
        rd_word[PCFS_ST_RANGE_BIT]   = range_ok;
        rd_word[PCFS_ST_SEL_LSB+:2]  = sel;
        rd_word[PCFS_ST_OEN_BIT]     = oen_s;
        rd_word[PCFS_ST_TEST_BIT]    = test_s;
      end
      PCFS_PERIOD_OFS: rd_word[PER_W-1:0] = period_q;
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr;
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // Clear strobe is write-one, self-clearing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q   <= PCFS_CTRL_RESET;
      sw_clr_q <= 1'b0;
    end else if (ce) begin
      sw_clr_q <= 1'b0;
      if (wr_pend_q && wr_addr_q == PCFS_CTRL_OFS) begin
        ctrl_q[1:0] <= hwdata[1:0];
        sw_clr_q    <= hwdata[PCFS_CTRL_CLR_BIT];
      end
    end
  end

  logic dbl_mode;
  assign dbl_mode = ctrl_q[PCFS_CTRL_DOUBLE_BIT];

  // Reference period measurement
  logic [PER_W-1:0] pcnt_q;
  localparam logic [PER_W-1:0] PER_SAT = '1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcnt_q    <= '0;
      period_q  <= '0;
      present_q <= 1'b0;
    end else if (ce) begin
      if (ref_rise) begin
        pcnt_q    <= '0;
        period_q  <= pcnt_q + 1'b1;
        present_q <= 1'b1;
      end else if (pcnt_q != PER_SAT) begin
        pcnt_q <= pcnt_q + 1'b1;
      end else begin
        present_q <= 1'b0;
      end
    end
  end

  // R3: rate window
  // R7: narrower reference window in double mode
  assign range_ok = present_q & (dbl_mode ?
    (period_q >= PER_W'(PCFS_PER_B_MIN) && period_q <= PER_W'(PCFS_PER_B_MAX)) :
    (period_q >= PER_W'(PCFS_PER_A_MIN) && period_q <= PER_W'(PCFS_PER_A_MAX)));

  // Oscillator runs at four times the reference; taps are 2x, 1x, 1/2x.
  // Only meaningful when the reference period spans 4+ hclk cycles.
  logic [PER_W-1:0] qcnt_q;
  logic [2:0]       osc_q;
  logic [PER_W-1:0] quarter;
  assign quarter = period_q >> 2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qcnt_q <= '0;
      osc_q  <= 3'h0;
    end else if (ce) begin
      // R2: realign on every reference rise
      if (ref_rise) begin
        qcnt_q     <= '0;
        osc_q[1:0] <= 2'h0;
      end else if (qcnt_q + 1'b1 >= quarter) begin
        qcnt_q <= '0;
        // R17: equal quarters give even duty on every tap
        if (osc_q[1:0] != 2'h3) begin
          osc_q[1:0] <= osc_q[1:0] + 2'h1;
        end
      end else begin
        qcnt_q <= qcnt_q + 1'b1;
      end
      // R14: clear resets the quarter divider, over the toggle
      if (clr_fall || sw_clr_q) begin
        osc_q[PCFS_OSC_HALF] <= 1'b0;
      end else if (ref_rise) begin
        osc_q[PCFS_OSC_HALF] <= ~osc_q[PCFS_OSC_HALF];
      end
    end
  end

  // Lock tracking: feedback rise close behind reference rise
  pcfs_lock_e       lk_q;
  logic [3:0]       lk_cnt_q;
  logic             fb_seen_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk_q      <= PCFS_LK_IDLE;
      lk_cnt_q  <= 4'h0;
      fb_seen_q <= 1'b0;
    end else if (ce) begin
      if (fb_rise && pcnt_q <= PER_W'(LOCK_TOL)) begin
        fb_seen_q <= 1'b1;
      end else if (ref_rise) begin
        fb_seen_q <= 1'b0;
      end
      case (lk_q)
        PCFS_LK_IDLE: begin
          lk_cnt_q <= 4'h0;
          if (present_q) begin
            lk_q <= PCFS_LK_ACQ;
          end
        end
        PCFS_LK_ACQ: begin
          if (!present_q) begin
            lk_q <= PCFS_LK_IDLE;
          end else if (oen_s) begin
            lk_cnt_q <= 4'h0;
          end else if (ref_rise) begin
            lk_cnt_q <= fb_seen_q ? lk_cnt_q + 4'h1 : 4'h0;
            if (fb_seen_q && lk_cnt_q + 4'h1 >= 4'(LOCK_COUNT)) begin
              lk_q <= PCFS_LK_LOCK;
            end
          end
        end
        PCFS_LK_LOCK: begin
          lk_cnt_q <= 4'h0;
          // R13: disabled outputs break the feedback loop
          if (!present_q || oen_s || (ref_rise && !fb_seen_q)) begin
            lk_q <= present_q ? PCFS_LK_ACQ : PCFS_LK_IDLE;
          end
        end
        default: lk_q <= PCFS_LK_IDLE;
      endcase
    end
  end

  assign locked = (lk_q == PCFS_LK_LOCK);

  // Output drivers
  logic       out_en;
  logic [2:0] bank_bit;
  logic       b4_bit;

  assign out_en = ~oen_s & ctrl_q[PCFS_CTRL_OE_BIT];

  always_comb begin
    for (int unsigned b = 0; b < 3; b++) begin
      // R6: selects move banks off unity rate
      // R9: doubled banks use the 2x tap
      // R10: code zero keeps banks one to three at unity
      // R11: bank one unity, others doubled
      // R12: banks one and two unity, bank three doubled
      if (pcfs_bank_alt(sel, b)) begin
        bank_bit[b] = dbl_mode ? osc_q[PCFS_OSC_DBL] : osc_q[PCFS_OSC_HALF];
      end else begin
        // R5: unity tap matches the reference for feedback use
        // R8: unity outputs at reference rate
        bank_bit[b] = osc_q[PCFS_OSC_UNI];
      end
    end
  end

  // R16: half the oscillator (2x tap) in double mode, 1x tap otherwise
  assign b4_bit = dbl_mode ? osc_q[PCFS_OSC_DBL] : osc_q[PCFS_OSC_UNI];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank1_clock_outputs <= 3'h0;
      bank2_clock_outputs <= 3'h0;
      bank3_clock_outputs <= 3'h0;
      bank4_clock_outputs <= 3'h0;
    end else if (ce) begin
      // R13: disabled outputs held low
      if (!out_en) begin
        bank1_clock_outputs <= 3'h0;
        bank2_clock_outputs <= 3'h0;
        bank3_clock_outputs <= 3'h0;
        bank4_clock_outputs <= 3'h0;
      // R15: loop bypassed in test
      end else if (test_s) begin
        bank1_clock_outputs <= {3{ref_lvl}};
        bank2_clock_outputs <= {3{ref_lvl}};
        bank3_clock_outputs <= {3{ref_lvl}};
        bank4_clock_outputs <= {3{ref_lvl}};
      // R1: twelve driven outputs
      end else begin
        bank1_clock_outputs <= {3{bank_bit[0]}};
        bank2_clock_outputs <= {3{bank_bit[1]}};
        bank3_clock_outputs <= {3{bank_bit[2]}};
        bank4_clock_outputs <= {3{b4_bit}};
      end
    end
  end

  logic run_gen;
  assign run_gen = ce & out_en & ~test_s;

  sequence s_oe_break;
    ce && oen_s;
  endsequence

  a_out_off_low: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    ce && !out_en |=> bank1_clock_outputs == 3'h0 &&
      bank4_clock_outputs == 3'h0)
    else $error("outputs not low while disabled");

  a_loop_broken: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    s_oe_break ##1 ce |-> lk_q != PCFS_LK_LOCK)
    else $error("lock held with outputs disabled");

  a_test_bypass: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    ce && out_en && test_s |=> bank2_clock_outputs == {3{$past(ref_lvl)}})
    else $error("test mode does not follow reference");

  a_ref_realign: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    ce && ref_rise |=> osc_q[1:0] == 2'h0 && qcnt_q == '0)
    else $error("phase not realigned on reference rise");

  a_clear_half: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    ce && clr_fall |=> osc_q[PCFS_OSC_HALF] == 1'b0)
    else $error("clear did not reset quarter divider");

  a_bank4_rate: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    run_gen |=> bank4_clock_outputs ==
      {3{$past(dbl_mode) ? $past(osc_q[0]) : $past(osc_q[1])}})
    else $error("bank four not at half oscillator");

  a_sel_all_uni: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    run_gen && sel == 2'h0 |=> bank3_clock_outputs == {3{$past(osc_q[1])}})
    else $error("select zero not all unity");

  a_sel_b1_uni: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    run_gen && dbl_mode && sel == 2'h2 |=>
      bank1_clock_outputs == {3{$past(osc_q[1])}} &&
      bank2_clock_outputs == {3{$past(osc_q[0])}})
    else $error("bank one only unity select wrong");

  a_sel_b12_uni: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    run_gen && dbl_mode && sel == 2'h3 |=>
      bank2_clock_outputs == {3{$past(osc_q[1])}} &&
      bank3_clock_outputs == {3{$past(osc_q[0])}})
    else $error("banks one and two unity select wrong");

  a_period_meas: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    ce && ref_rise |=> period_q == $past(pcnt_q) + 1'b1)
    else $error("reference period mismeasured");

endmodule // pcfs_top

/* File: verif/pcfs_ref_model.sv */
`timescale 1ns/1ns
module pcfs_ref_model (
  input  wire logic       hclk,
  input  wire logic [7:0] half_per,
  input  wire logic       fb_src,
  output logic            ref_p,
  output logic            ref_n,
  output logic            fb_out
);
  logic [7:0] cnt_q;

  initial begin
    ref_p = 1'b0;
    cnt_q = 8'h0;
  end

  // Free-running source; edges land just after hclk
  always @(posedge hclk) begin
    if (cnt_q + 8'h1 >= half_per) begin
      cnt_q <= 8'h0;
      ref_p <= ~ref_p;
    end else begin
      cnt_q <= cnt_q + 8'h1;
    end
  end

  assign ref_n = ~ref_p;
  assign fb_out = fb_src;
endmodule // pcfs_ref_model

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import pcfs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic        ref_p, ref_n, fb, sel_hi, sel_lo, oe_n, clr_n, tst_b;
  logic [2:0]  b1, b2, b3, b4;
  logic [7:0]  half_per;
  int          mismatches, check_count, per, seed_v;

  pcfs_top u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ref_clock_pair_p(ref_p), .ref_clock_pair_n(ref_n),
    .loop_feedback_in(fb), .bank_cfg_select_hi(sel_hi),
    .bank_cfg_select_lo(sel_lo), .output_enable_n(oe_n),
    .divider_clear_n(clr_n), .test_bypass(tst_b),
    .bank1_clock_outputs(b1), .bank2_clock_outputs(b2),
    .bank3_clock_outputs(b3), .bank4_clock_outputs(b4));

  pcfs_ref_model u_ref (.hclk(hclk), .half_per(half_per), .fb_src(b1[0]),
    .ref_p(ref_p), .ref_n(ref_n), .fb_out(fb));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_eq(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int e, input int tol,
                         input int g);
    check_count++;
    if (g < e - tol || g > e + tol) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      $display("[FAIL] hready expected 1 seen %b", hreadyout);
      tally_and_finish();
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a,
                        input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk_eq(nm, e, r);
  endtask

  // Model: twice the rate of a bank relative to the reference
  function automatic int rate2(input int b, input int sel, input int dbl,
                               input int tst);
    int alt;
    alt = (sel == 2 && b != 0) || (sel == 3 && b == 2);
    if (tst != 0) return 2;
    if (b == 3) return dbl != 0 ? 4 : 2;
    if (alt == 0) return 2;
    return dbl != 0 ? 4 : 1;
  endfunction

  task automatic run_cfg(input int sel, input int dbl, input int tst,
                         input int pin_en, input int sw_en);
    int rise[4];
    int high[4];
    int w, en, same;
    logic [11:0] prv, cur;
    en = pin_en & sw_en;
    same = 1;
    sel_hi <= sel[1];
    sel_lo <= sel[0];
    tst_b <= tst[0];
    oe_n <= ~pin_en[0];
    bus(1'b1, PCFS_CTRL_OFS, {29'h0, 1'b0, sw_en[0], dbl[0]}, d);
    clr_n <= 1'b0;
    @(posedge hclk);
    clr_n <= 1'b1;
    repeat (6 * per) @(posedge hclk);
    w = 8 * per;
    for (int b = 0; b < 4; b++) begin
      rise[b] = 0;
      high[b] = 0;
    end
    prv = {b4, b3, b2, b1};
    repeat (w) begin
      @(posedge hclk);
      #1;
      cur = {b4, b3, b2, b1};
      for (int b = 0; b < 4; b++) begin
        if (prv[3*b] === 1'b0 && cur[3*b] === 1'b1) rise[b]++;
        if (cur[3*b] === 1'b1) high[b]++;
        if (cur[3*b+:3] !== {3{cur[3*b]}}) same = 0;
      end
      prv = cur;
    end
    chk_rng("bank bits equal", 1, 0, same);
    for (int b = 0; b < 4; b++) begin
      chk_rng("bank rises", en * 4 * rate2(b, sel, dbl, tst), 1, rise[b]);
      chk_rng("bank duty", en * w / 2, en * per, high[b]);
    end
    bus(1'b0, PCFS_STATUS_OFS, 32'h0, d);
    chk_eq("status pins", {28'h0, tst[0], ~pin_en[0], sel[1:0]},
           {28'h0, d[7:4]});
    $display("Test sel %0d dbl %0d tst %0d en %0d/%0d done",
             sel, dbl, tst, pin_en, sw_en);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    sel_hi = 1'b0;
    sel_lo = 1'b0;
    oe_n = 1'b0;
    clr_n = 1'b1;
    tst_b = 1'b0;
    mismatches = 0;
    check_count = 0;
    per = 32;
    half_per = 8'h10;
    seed_v = $urandom(32'hd3c9);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("ctrl reset", PCFS_CTRL_OFS, 32'h2);
    rd_chk("unmapped", 32'h0000_000c, 32'h0);
    bus(1'b1, PCFS_CTRL_OFS, 32'h7, d);
    rd_chk("ctrl clear bit", PCFS_CTRL_OFS, 32'h3);
    per = 32 + 4 * ($urandom % 5);
    half_per <= 8'(per / 2);
    repeat (5 * per) @(posedge hclk);
    rd_chk("period", PCFS_PERIOD_OFS, 32'(per));
    bus(1'b0, PCFS_STATUS_OFS, 32'h0, d);
    chk_eq("status range", 32'h1, {30'h0, d[2:1]});
    $display("Test registers done");
    for (int dbl = 0; dbl < 2; dbl++) begin
      for (int s = 0; s < 4; s++) run_cfg(s, dbl, 0, 1, 1);
    end
    run_cfg($urandom % 4, 1, 1, 1, 1);
    run_cfg(2, 0, 0, 0, 1);
    run_cfg(3, 1, 0, 1, 0);
    run_cfg(2, 0, 0, 1, 1);
    tally_and_finish();
  end
endmodule // tb_top
